/* logic/dcfm_consts.vh */
// constants used by the mailbox fifo core, not by its staging buffer
`ifndef DCFM_CONSTS_VH
`define DCFM_CONSTS_VH

// ----------------------------------------------------------------
// port sample vector layout (same for both ports)
// ----------------------------------------------------------------
`define DCFM_PV_W 42
`define DCFM_PV_CLK 41
`define DCFM_PV_CS_N 40
`define DCFM_PV_EN 39
`define DCFM_PV_DIR 38
`define DCFM_PV_MB 37
`define DCFM_PV_PG 36
`define DCFM_PV_DATA_HI 35
`define DCFM_PV_DATA_LO 0

// ----------------------------------------------------------------
// shared input vector layout
// ----------------------------------------------------------------
`define DCFM_MV_W 3
`define DCFM_MV_ODD 2
`define DCFM_MV_SEL_HI 1
`define DCFM_MV_SEL_LO 0

// ----------------------------------------------------------------
// almost-flag offset presets, indexed by {sel_hi, sel_lo}
// ----------------------------------------------------------------
`define DCFM_OFFSET_0 7'h10
`define DCFM_OFFSET_1 7'h0c
`define DCFM_OFFSET_2 7'h08
`define DCFM_OFFSET_3 7'h04

// ----------------------------------------------------------------
// reset values of flags and data
// ----------------------------------------------------------------
`define DCFM_RST_FULL_N 1'b0
`define DCFM_RST_AFULL_N 1'b1
`define DCFM_RST_EMPTY_N 1'b0
`define DCFM_RST_AEMPTY_N 1'b0
`define DCFM_RST_MAIL_N 1'b1
`define DCFM_RST_PERR_N 1'b1
`define DCFM_RST_WORD 36'h000000000

`endif

/* logic/dcfm_core.v */
// mailbox fifo core: 64x36 fifo from write port to read port, two mailboxes, parity
`timescale 1ns/1ps
`include "dcfm_consts.vh"

// How it works
// - holds up to 64 words of 36 bits, passed in order write port to read port
// - each transfer happens on its own port clock rising edge, qualified by enables
// - a port's data bus is released while its select is high
// - full flags update on write-port edges, empty flags on read-port edges, two stages
// - almost-empty is low while stored count is at or below the offset
// - almost-full is low while free locations are at or below the offset
// - no fifo read while empty is low; otherwise read loads the output register
// - empty low at reset, high on second read-port edge after a write
// - full blocks writes; low at reset, high on second write-port edge after
// - reset release latches the two offset selects into one of four presets
// - write-port mailbox select steers that port's access to a mailbox
// - read port drives forward mailbox when its mailbox select is high, else fifo data
// - writing the forward mailbox drops its flag; writes ignored while flag low
// - forward flag returns high on a read-port mailbox read, and at reset
// - two 36-bit mailboxes, one per direction, each with a new-mail flag
// - parity checking is passive and never changes data flow
// - parity generation is a selectable option on data read from each port
// - reset held low for four edges per port; sets flags to their reset values
// - reverse mailbox written by read port drops flag; write-port read raises it
// - parity per 9-bit byte, top bit parity; error low on any failing byte, held high during a generating mailbox read
module dcfm_core #(
    parameter DEPTH = 64,
    parameter AW = 6,
    parameter STAGE_DEPTH = 8
) (
    // clock and reset
    input wire core_clk,
    input wire reset_n,
    // write-port pins
    input wire write_port_clock,
    input wire wr_side_select_n,
    input wire wr_side_enable,
    input wire wr_side_dir,
    input wire wr_side_mailbox_sel,
    input wire wr_side_parity_gen,
    input wire [35:0] wr_side_data_in,
    output reg [35:0] wr_side_data_out,
    output reg wr_side_data_oe,
    output reg wr_side_parity_err_n,
    // read-port pins
    input wire read_port_clock,
    input wire rd_side_select_n,
    input wire rd_side_enable,
    input wire rd_side_dir,
    input wire rd_side_mailbox_sel,
    input wire rd_side_parity_gen,
    input wire [35:0] rd_side_data_in,
    output reg [35:0] rd_side_data_out,
    output reg rd_side_data_oe,
    output reg rd_side_parity_err_n,
    // shared configuration
    input wire parity_odd,
    input wire offset_sel_lo,
    input wire offset_sel_hi,
    // flags
    output reg full_flag_n,
    output reg almost_full_n,
    output reg empty_flag_n,
    output reg almost_empty_n,
    output reg fwd_mail_flag_n,
    output reg rev_mail_flag_n
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function [AW:0] to_gray;
        input [AW:0] b;
        begin
            to_gray = b ^ (b >> 1);
        end
    endfunction

    function [AW:0] from_gray;
        input [AW:0] g;
        integer i;
        begin
            from_gray[AW] = g[AW];
            for (i = AW - 1; i >= 0; i = i - 1) begin
                from_gray[i] = from_gray[i+1] ^ g[i];
            end
        end
    endfunction

    // all four bytes pass the selected parity
    function parity_ok;
        input [35:0] d;
        input odd;
        begin
            parity_ok = ((^d[8:0]) == odd) & ((^d[17:9]) == odd) &
                        ((^d[26:18]) == odd) & ((^d[35:27]) == odd);
        end
    endfunction

    // replace the top bit of each byte with generated parity
    function [35:0] parity_fill;
        input [35:0] d;
        input odd;
        begin
            parity_fill = {(^d[34:27]) ^ odd, d[34:27], (^d[25:18]) ^ odd, d[25:18],
                           (^d[16:9]) ^ odd, d[16:9], (^d[7:0]) ^ odd, d[7:0]};
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg [`DCFM_PV_W-1:0] a_s1;
    reg [`DCFM_PV_W-1:0] a_s2;
    reg [`DCFM_PV_W-1:0] b_s1;
    reg [`DCFM_PV_W-1:0] b_s2;
    reg [`DCFM_MV_W-1:0] m_s1;
    reg [`DCFM_MV_W-1:0] m_s2;
    reg a_clk_q;
    reg b_clk_q;
    reg reset_q;

    // port and config pins cross two flops, reset_n one; port clocks are sampled as plain levels,
    // so each port clock must run below a quarter of core_clk
    always @(posedge core_clk) begin
        a_s1 <= {write_port_clock, wr_side_select_n, wr_side_enable, wr_side_dir,
                 wr_side_mailbox_sel, wr_side_parity_gen, wr_side_data_in};
        a_s2 <= a_s1;
        b_s1 <= {read_port_clock, rd_side_select_n, rd_side_enable, rd_side_dir,
                 rd_side_mailbox_sel, rd_side_parity_gen, rd_side_data_in};
        b_s2 <= b_s1;
        m_s1 <= {parity_odd, offset_sel_hi, offset_sel_lo};
        m_s2 <= m_s1;
        a_clk_q <= a_s2[`DCFM_PV_CLK];
        b_clk_q <= b_s2[`DCFM_PV_CLK];
        reset_q <= reset_n;
    end

    // decoded port cycles; controls are aligned with the clock samples
    wire a_edge = a_s2[`DCFM_PV_CLK] & ~a_clk_q;
    wire b_edge = b_s2[`DCFM_PV_CLK] & ~b_clk_q;
    wire a_act = ~a_s2[`DCFM_PV_CS_N] & a_s2[`DCFM_PV_EN];
    wire b_act = ~b_s2[`DCFM_PV_CS_N] & b_s2[`DCFM_PV_EN];
    wire a_mb = a_s2[`DCFM_PV_MB];
    wire b_mb = b_s2[`DCFM_PV_MB];
    wire a_wr = a_edge & a_act & a_s2[`DCFM_PV_DIR];
    wire a_rd = a_edge & a_act & ~a_s2[`DCFM_PV_DIR];
    wire b_wr = b_edge & b_act & b_s2[`DCFM_PV_DIR];
    wire b_rd = b_edge & b_act & ~b_s2[`DCFM_PV_DIR];
    wire odd = m_s2[`DCFM_MV_ODD];
    wire [35:0] a_din = a_s2[`DCFM_PV_DATA_HI:`DCFM_PV_DATA_LO];
    wire [35:0] b_din = b_s2[`DCFM_PV_DATA_HI:`DCFM_PV_DATA_LO];

    // ------------------------------------------------------------
    // offset latched at reset release
    // ------------------------------------------------------------
    reg [AW:0] offset;

    // tracks the selects in reset, freezes on release: never unknown at a flag update
    always @(posedge core_clk) begin
        if (!reset_q) begin
            case (m_s2[`DCFM_MV_SEL_HI:`DCFM_MV_SEL_LO])
                2'h0: offset <= `DCFM_OFFSET_0;
                2'h1: offset <= `DCFM_OFFSET_1;
                2'h2: offset <= `DCFM_OFFSET_2;
                default: offset <= `DCFM_OFFSET_3;
            endcase
        end
    end

    // ------------------------------------------------------------
    // staging buffer and main array
    // ------------------------------------------------------------
    reg [35:0] mem [0:DEPTH-1];
    reg [AW:0] wr_bin;
    reg [AW:0] rd_bin;
    reg [AW:0] rd_gray_a;
    reg [AW:0] wr_gray_b;
    reg full_arm;
    reg [35:0] fifo_out;
    wire stage_valid;
    wire stage_ready;
    wire [35:0] stage_data;
    wire [3:0] stage_level;
    wire fifo_push = a_wr & ~a_mb & full_flag_n;
    wire array_room = ((wr_bin - rd_bin) != DEPTH[AW:0]);
    wire array_load = stage_valid & array_room;
    wire fifo_pop = b_rd & ~b_mb & empty_flag_n;

    // write-side words wait here one cycle before entering the array;
    // the array refusing a word stalls the drain side
    dcfm_stage_fifo #(
        .WIDTH(36),
        .DEPTH(STAGE_DEPTH),
        .AW(3)
    ) u_stage (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_valid(fifo_push),
        .in_ready(stage_ready),
        .in_data(a_din),
        .out_valid(stage_valid),
        .out_ready(array_room),
        .out_data(stage_data),
        .level(stage_level)
    );

    // array write from the staging buffer
    always @(posedge core_clk) begin
        if (array_load) begin
            mem[wr_bin[AW-1:0]] <= stage_data;
        end
    end

    // occupancy seen from the write port counts staged words too, so the
    // full flag covers the whole path; read pointer is the delayed gray copy
    wire [AW:0] next_occ_a = wr_bin - from_gray(rd_gray_a) + {3'h0, stage_level} +
                             {{AW{1'b0}}, fifo_push & stage_ready};
    wire [AW:0] next_free_a = DEPTH[AW:0] - next_occ_a;
    wire [AW:0] next_rd_bin = rd_bin + {{AW{1'b0}}, fifo_pop};
    wire [AW:0] next_cnt_b = from_gray(wr_gray_b) - next_rd_bin;

    // pointers, gray copies and flags
    always @(posedge core_clk) begin
        if (!reset_n) begin
            wr_bin <= {(AW+1){1'b0}};
            rd_bin <= {(AW+1){1'b0}};
            rd_gray_a <= {(AW+1){1'b0}};
            wr_gray_b <= {(AW+1){1'b0}};
            full_arm <= 1'b0;
            fifo_out <= `DCFM_RST_WORD;
            full_flag_n <= `DCFM_RST_FULL_N;
            almost_full_n <= `DCFM_RST_AFULL_N;
            empty_flag_n <= `DCFM_RST_EMPTY_N;
            almost_empty_n <= `DCFM_RST_AEMPTY_N;
        end else begin
            if (array_load) begin
                wr_bin <= wr_bin + 1'b1;
            end
            if (fifo_pop) begin
                fifo_out <= mem[rd_bin[AW-1:0]];
                rd_bin <= next_rd_bin;
            end
            // write-port side: gray read pointer is stage one, flags stage two
            if (a_edge) begin
                rd_gray_a <= to_gray(rd_bin);
                full_arm <= 1'b1;
                full_flag_n <= full_arm & (next_occ_a < DEPTH[AW:0]);
                almost_full_n <= (next_free_a > offset);
            end
            // read-port side: gray write pointer is stage one, flags stage two
            if (b_edge) begin
                wr_gray_b <= to_gray(wr_bin);
                empty_flag_n <= (next_cnt_b != {(AW+1){1'b0}});
                almost_empty_n <= (next_cnt_b > offset);
            end
        end
    end

    // ------------------------------------------------------------
    // mailboxes
    // ------------------------------------------------------------
    reg [35:0] fwd_mailbox;
    reg [35:0] rev_mailbox;

    // a write and a read in one cycle leave the flag low: new mail wins
    always @(posedge core_clk) begin
        if (!reset_n) begin
            fwd_mailbox <= `DCFM_RST_WORD;
            rev_mailbox <= `DCFM_RST_WORD;
            fwd_mail_flag_n <= `DCFM_RST_MAIL_N;
            rev_mail_flag_n <= `DCFM_RST_MAIL_N;
        end else begin
            if (a_wr && a_mb && fwd_mail_flag_n) begin
                fwd_mailbox <= a_din;
                fwd_mail_flag_n <= 1'b0;
            end else if (b_rd && b_mb) begin
                fwd_mail_flag_n <= 1'b1;
            end
            if (b_wr && b_mb && rev_mail_flag_n) begin
                rev_mailbox <= b_din;
                rev_mail_flag_n <= 1'b0;
            end else if (a_rd && a_mb) begin
                rev_mail_flag_n <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // bus drive and parity
    // ------------------------------------------------------------
    wire a_out_on = ~a_s2[`DCFM_PV_CS_N] & ~a_s2[`DCFM_PV_DIR];
    wire b_out_on = ~b_s2[`DCFM_PV_CS_N] & ~b_s2[`DCFM_PV_DIR];
    wire a_gen = a_s2[`DCFM_PV_PG];
    wire b_gen = b_s2[`DCFM_PV_PG];
    wire [35:0] b_src = b_mb ? fwd_mailbox : fifo_out;

    // the parity trees are shared with generation, so a generating mailbox
    // read forces the error flag of that port inactive
    always @(posedge core_clk) begin
        if (!reset_n) begin
            wr_side_data_out <= `DCFM_RST_WORD;
            rd_side_data_out <= `DCFM_RST_WORD;
            wr_side_data_oe <= 1'b0;
            rd_side_data_oe <= 1'b0;
            wr_side_parity_err_n <= `DCFM_RST_PERR_N;
            rd_side_parity_err_n <= `DCFM_RST_PERR_N;
        end else begin
            wr_side_data_oe <= a_out_on;
            rd_side_data_oe <= b_out_on;
            wr_side_data_out <= a_gen ? parity_fill(rev_mailbox, odd) : rev_mailbox;
            rd_side_data_out <= b_gen ? parity_fill(b_src, odd) : b_src;
            // check result is only reported, data path ignores it
            if (a_act && a_out_on && a_mb && a_gen) begin
                wr_side_parity_err_n <= 1'b1;
            end else begin
                wr_side_parity_err_n <= parity_ok(a_din, odd);
            end
            if (b_act && b_out_on && b_mb && b_gen) begin
                rd_side_parity_err_n <= 1'b1;
            end else begin
                rd_side_parity_err_n <= parity_ok(b_din, odd);
            end
        end
    end
endmodule // dcfm_core

/* logic/dcfm_stage_fifo.v */
// small staging fifo with valid/ready on both sides
`timescale 1ns/1ps
module dcfm_stage_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire core_clk,
    input wire reset_n,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    // occupancy
    output wire [AW:0] level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_idx;
    reg [AW-1:0] rd_idx;
    reg [AW:0] count;
    wire push;
    wire pop;

    // ------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------
    // full and empty come straight from the count
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_idx];
    assign level = count;

    // storage write, no reset needed on the array
    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_idx] <= in_data;
        end
    end

    // pointers wrap at depth so depth need not be a power of two
    always @(posedge core_clk) begin
        if (!reset_n) begin
            wr_idx <= {AW{1'b0}};
            rd_idx <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_idx <= (wr_idx == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_idx + 1'b1;
            end
            if (pop) begin
                rd_idx <= (rd_idx == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_idx + 1'b1;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // dcfm_stage_fifo

/* testbench/dcfm_core_assertions.sv */
// concurrent checks on the ports of the mailbox fifo core
`timescale 1ns/1ps
module dcfm_core_chk (
    // clock and reset
    input wire core_clk,
    input wire reset_n,
    // port pins
    input wire write_port_clock,
    input wire read_port_clock,
    input wire wr_side_select_n,
    input wire rd_side_select_n,
    input wire rd_side_enable,
    input wire rd_side_dir,
    input wire rd_side_mailbox_sel,
    input wire rd_side_parity_gen,
    input wire wr_side_data_oe,
    input wire rd_side_data_oe,
    input wire rd_side_parity_err_n,
    // flags
    input wire full_flag_n,
    input wire almost_full_n,
    input wire empty_flag_n,
    input wire almost_empty_n,
    input wire fwd_mail_flag_n,
    input wire rev_mail_flag_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------------------------------
    // cycles since each port clock last rose, saturating
    // ----------------------------------------------------------------
    reg pa;
    reg pb;
    reg [3:0] age_a;
    reg [3:0] age_b;
    // a flag moving far from its port edge took the wrong clock
    always @(posedge core_clk) begin
        pa <= write_port_clock;
        pb <= read_port_clock;
        age_a <= (write_port_clock && !pa) ? 4'h0 : ((age_a == 4'hf) ? age_a : age_a + 4'h1);
        age_b <= (read_port_clock && !pb) ? 4'h0 : ((age_b == 4'hf) ? age_b : age_b + 4'h1);
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_rst;
        disable iff (1'b0) !reset_n |=> !full_flag_n && almost_full_n && !empty_flag_n && !almost_empty_n
            && fwd_mail_flag_n && rev_mail_flag_n;
    endproperty
    a_rst: assert property (p_rst) else $error("flags wrong after reset");
    property p_e_dom;
        $changed(empty_flag_n) |-> age_b <= 4'h6;
    endproperty
    a_e_dom: assert property (p_e_dom) else $error("empty flag moved off a read edge");
    property p_f_dom;
        $changed(full_flag_n) || $changed(almost_full_n) |-> age_a <= 4'h6;
    endproperty
    a_f_dom: assert property (p_f_dom) else $error("full flags moved off a write edge");
    property p_hiz_a;
        $past(wr_side_select_n, 3) |-> !wr_side_data_oe;
    endproperty
    a_hiz_a: assert property (p_hiz_a) else $error("write side drives while deselected");
    property p_oe_b;
        rd_side_data_oe |-> $past(!rd_side_select_n && !rd_side_dir, 3);
    endproperty
    a_oe_b: assert property (p_oe_b) else $error("read side drives without a read select");
    property p_fwd_fall;
        $fell(fwd_mail_flag_n) |-> age_a <= 4'h6;
    endproperty
    a_fwd_fall: assert property (p_fwd_fall) else $error("mail flag fell off a write edge");
    property p_ae_imp;
        !empty_flag_n |-> !almost_empty_n;
    endproperty
    a_ae_imp: assert property (p_ae_imp) else $error("almost empty high while empty");
    property p_perr_gen;
        $past(!rd_side_select_n && rd_side_enable && !rd_side_dir && rd_side_mailbox_sel && rd_side_parity_gen, 3)
            |-> rd_side_parity_err_n;
    endproperty
    a_perr_gen: assert property (p_perr_gen) else $error("parity error not forced high");
    c_full: cover property ($fell(full_flag_n));
    c_mail: cover property ($fell(fwd_mail_flag_n));
    c_data: cover property ($rose(empty_flag_n));
endmodule // dcfm_core_chk

bind dcfm_core dcfm_core_chk dcfm_core_chk_i (
    .core_clk, .reset_n, .write_port_clock, .read_port_clock, .wr_side_select_n, .rd_side_select_n,
    .rd_side_enable, .rd_side_dir, .rd_side_mailbox_sel, .rd_side_parity_gen, .wr_side_data_oe,
    .rd_side_data_oe, .rd_side_parity_err_n, .full_flag_n, .almost_full_n, .empty_flag_n, .almost_empty_n,
    .fwd_mail_flag_n, .rev_mail_flag_n
);

/* testbench/dcfm_port_partner.sv */
// free-running port clock sources standing in for the two port masters
`timescale 1ns/1ps
module dcfm_port_partner #(
    parameter HALF_A = 100,
    parameter HALF_B = 125
) (
    // port clocks
    output reg write_port_clock,
    output reg read_port_clock
);
    // free-running and unrelated; each half period spans several core cycles
    initial begin
        write_port_clock = 1'b0;
        forever #(HALF_A) write_port_clock = ~write_port_clock;
    end
    // odd start offset keeps the read side off the write side's phase
    initial begin
        read_port_clock = 1'b0;
        #37;
        forever #(HALF_B) read_port_clock = ~read_port_clock;
    end
endmodule // dcfm_port_partner

/* testbench/test_dcfm_core.sv */
// self-checking bench for the mailbox fifo core
`timescale 1ns/1ps
module test_dcfm_core;
    reg core_clk, reset_n, parity_odd, offset_sel_lo, offset_sel_hi;
    reg wr_side_select_n, wr_side_enable, wr_side_dir, wr_side_mailbox_sel, wr_side_parity_gen;
    reg rd_side_select_n, rd_side_enable, rd_side_dir, rd_side_mailbox_sel, rd_side_parity_gen;
    reg [35:0] wr_side_data_in, rd_side_data_in;
    wire [35:0] wr_side_data_out, rd_side_data_out;
    wire write_port_clock, read_port_clock, wr_side_data_oe, rd_side_data_oe;
    wire wr_side_parity_err_n, rd_side_parity_err_n, full_flag_n, almost_full_n;
    wire empty_flag_n, almost_empty_n, fwd_mail_flag_n, rev_mail_flag_n;
    integer n_mismatch, n_compared, cycles, i;
    localparam [35:0] BASE = 36'h900000000;

    dcfm_port_partner dcfm_port_partner_i (.write_port_clock, .read_port_clock);
    dcfm_core dcfm_core_i (
        .core_clk, .reset_n, .write_port_clock, .wr_side_select_n, .wr_side_enable, .wr_side_dir,
        .wr_side_mailbox_sel, .wr_side_parity_gen, .wr_side_data_in, .wr_side_data_out, .wr_side_data_oe,
        .wr_side_parity_err_n, .read_port_clock, .rd_side_select_n, .rd_side_enable, .rd_side_dir,
        .rd_side_mailbox_sel, .rd_side_parity_gen, .rd_side_data_in, .rd_side_data_out, .rd_side_data_oe,
        .rd_side_parity_err_n, .parity_odd, .offset_sel_lo, .offset_sel_hi, .full_flag_n, .almost_full_n,
        .empty_flag_n, .almost_empty_n, .fwd_mail_flag_n, .rev_mail_flag_n
    );
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task check(input [35:0] seen, input [35:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // sets the top bit of each 9-bit byte to parity
    function [35:0] genpar(input [35:0] d, input odd);
        integer k;
        begin
            genpar = d;
            for (k = 0; k < 4; k = k + 1)
                genpar[9*k+8] = ^d[9*k +: 8] ^ odd;
        end
    endfunction
    // pins change in the low phase and hold across the next rise
    task pa(input s, input e, input d, input m, input [35:0] v);
        begin
            @(negedge write_port_clock);
            @(posedge core_clk);
            #2;
            {wr_side_select_n, wr_side_enable, wr_side_dir, wr_side_mailbox_sel, wr_side_data_in} = {s, e, d, m, v};
        end
    endtask
    task pb(input s, input e, input d, input m, input [35:0] v);
        begin
            @(negedge read_port_clock);
            @(posedge core_clk);
            #2;
            {rd_side_select_n, rd_side_enable, rd_side_dir, rd_side_mailbox_sel, rd_side_data_in} = {s, e, d, m, v};
        end
    endtask
    // settle: a few port edges then the register pipeline
    task settle(input integer n);
        begin
            repeat (n) @(posedge read_port_clock);
            repeat (n) @(posedge write_port_clock);
            repeat (6) @(posedge core_clk);
            #2;
        end
    endtask
    task print_verdict;
        begin
            $display("compared %0d mismatches %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset;
        begin
            check({full_flag_n, almost_full_n, empty_flag_n, almost_empty_n}, 36'h4);
            check({fwd_mail_flag_n, rev_mail_flag_n}, 36'h3);
            settle(3);
            check(full_flag_n, 36'h1);
            $display("reset test done");
        end
    endtask
    // fill past full, then drain in order and read once more while empty
    task t_fifo;
        begin
            for (i = 0; i < 59; i = i + 1)
                pa(0, 1, 1, 0, BASE + i);
            pa(1, 0, 0, 0, 36'h0);
            settle(3);
            check({almost_full_n, empty_flag_n, almost_empty_n}, 36'h7);
            pa(0, 1, 1, 0, BASE + 59);
            pa(1, 0, 0, 0, 36'h0);
            settle(3);
            check(almost_full_n, 36'h0);
            for (i = 60; i < 65; i = i + 1)
                pa(0, 1, 1, 0, BASE + i);
            pa(1, 0, 0, 0, 36'h0);
            settle(3);
            check(full_flag_n, 36'h0);
            for (i = 0; i < 64; i = i + 1) begin
                pb(0, 1, 0, 0, 36'h0);
                pb(0, 0, 0, 0, 36'h0);
                check(rd_side_data_out, BASE + i);
            end
            settle(3);
            check({empty_flag_n, almost_empty_n}, 36'h0);
            pb(0, 1, 0, 0, 36'h0);
            pb(0, 0, 0, 0, 36'h0);
            settle(1);
            check(rd_side_data_out, BASE + 63);
            pb(1, 0, 0, 0, 36'h0);
            $display("fifo test done");
        end
    endtask
    task t_mail;
        begin
            pa(0, 1, 1, 1, 36'h000000003);
            pa(0, 1, 1, 1, 36'h0000000f0);
            pa(1, 0, 0, 0, 36'h0);
            settle(2);
            check(fwd_mail_flag_n, 36'h0);
            rd_side_parity_gen = 1'b1;
            pb(0, 1, 0, 1, 36'h0);
            pb(0, 0, 0, 1, 36'h0);
            settle(1);
            check(rd_side_data_out, genpar(36'h000000003, 1'b1));
            pb(1, 0, 0, 0, 36'h0);
            rd_side_parity_gen = 1'b0;
            settle(2);
            check({fwd_mail_flag_n, rd_side_data_oe}, 36'h2);
            pb(0, 1, 1, 1, 36'h5a5a5a5a5);
            pb(1, 0, 0, 0, 36'h0);
            settle(2);
            check(rev_mail_flag_n, 36'h0);
            pa(0, 1, 0, 1, 36'h0);
            pa(0, 0, 0, 1, 36'h0);
            settle(1);
            check(wr_side_data_out, 36'h5a5a5a5a5);
            check(wr_side_data_oe, 36'h1);
            {wr_side_parity_gen, parity_odd} = 2'h2;
            settle(1);
            check(wr_side_data_out, genpar(36'h5a5a5a5a5, 1'b0));
            {wr_side_parity_gen, parity_odd} = 2'h1;
            pa(0, 0, 1, 0, genpar(36'h012345678, 1'b1));
            settle(2);
            check({rev_mail_flag_n, wr_side_parity_err_n}, 36'h3);
            pa(0, 0, 1, 0, genpar(36'h012345678, 1'b1) ^ 36'h000000100);
            settle(1);
            check(wr_side_parity_err_n, 36'h0);
            pa(1, 0, 0, 0, 36'h0);
            $display("mailbox and parity test done");
        end
    endtask
    // ----------------------------------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // ceiling far above the ~3000 cycles needed
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            print_verdict;
        end
    end
    initial begin
        {n_mismatch, n_compared, cycles} = 0;
        {reset_n, parity_odd, offset_sel_lo, offset_sel_hi} = 4'h7;
        {wr_side_select_n, wr_side_enable, wr_side_dir, wr_side_mailbox_sel, wr_side_parity_gen} = 5'h10;
        {rd_side_select_n, rd_side_enable, rd_side_dir, rd_side_mailbox_sel, rd_side_parity_gen} = 5'h10;
        {wr_side_data_in, rd_side_data_in} = 72'h0;
        // over four rises of each port clock
        repeat (60) @(posedge core_clk);
        #2;
        reset_n = 1'b1;
        @(posedge core_clk);
        #2;
        t_reset;
        t_fifo;
        t_mail;
        print_verdict;
    end
endmodule // test_dcfm_core
